// ==== common/sncr_pkg.sv ====
package sncr_pkg;
	// Register numbers of the node configuration space
	localparam logic [7:0] SNCR_REG_DEV_ID = 8'h00;
	localparam logic [7:0] SNCR_REG_SW_DESC = 8'h01;
	localparam logic [7:0] SNCR_REG_SW_CFG = 8'h04;
	localparam logic [7:0] SNCR_REG_NODE_ID = 8'h05;
	localparam logic [7:0] SNCR_REG_PLL = 8'h06;
	localparam logic [7:0] SNCR_REG_SW_CLK_DIV = 8'h07;
	localparam logic [7:0] SNCR_REG_REF_CLK_DIV = 8'h08;
	localparam logic [7:0] SNCR_REG_SCAN_ID = 8'h09;
	localparam logic [7:0] SNCR_REG_USER_CODE = 8'h0A;
	localparam logic [7:0] SNCR_REG_DIR_LOW = 8'h0C;
	localparam logic [7:0] SNCR_REG_DIR_HIGH = 8'h0D;
	localparam logic [7:0] SNCR_REG_DBG_TILE0 = 8'h10;

	// Switch configuration fields
	localparam int SNCR_CFG_LOCK_ALL_BIT = 31;
	localparam int SNCR_CFG_LOCK_PLL_BIT = 8;
	localparam int SNCR_CFG_HDR_BIT = 0;

	// PLL settings fields
	localparam int SNCR_PLL_NO_RESET_BIT = 31;
	localparam int SNCR_PLL_NO_RELOCK_BIT = 30;
	localparam int SNCR_PLL_BYPASS_BIT = 29;
	localparam int SNCR_PLL_JTAG_BOOT_BIT = 28;
	localparam int SNCR_PLL_OUT_DIV_HI = 25;
	localparam int SNCR_PLL_OUT_DIV_LO = 23;
	localparam int SNCR_PLL_FB_MUL_HI = 20;
	localparam int SNCR_PLL_FB_MUL_LO = 8;
	localparam int SNCR_PLL_IN_DIV_HI = 6;
	localparam int SNCR_PLL_IN_DIV_LO = 0;
	// Writable bits of the PLL settings register
	localparam logic [31:0] SNCR_PLL_WMASK = 32'hF39FFF7F;

	// Debug pin configuration fields
	localparam int SNCR_DBG_DRIVE_BIT = 0;
	localparam int SNCR_DBG_REQ_BIT = 1;

	// Reset values
	localparam logic [31:0] SNCR_PLL_RST = 32'h00000000;
	localparam logic [15:0] SNCR_NODE_ID_RST = 16'h0000;
	localparam logic [15:0] SNCR_SW_CLK_DIV_RST = 16'h0000;
	localparam logic [15:0] SNCR_REF_CLK_DIV_RST = 16'h0003;
	localparam logic [31:0] SNCR_DIR_RST = 32'h00000000;

	// Time allowed after a PLL change before lock is trusted again
	localparam int SNCR_CLK_MHZ = 25;
	localparam int SNCR_PLL_SETTLE_NS = 400;
	localparam int SNCR_PLL_SETTLE_CYC =
		(SNCR_PLL_SETTLE_NS * SNCR_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SNCR_SETTLE_LAST = 8'(SNCR_PLL_SETTLE_CYC - 1);

	// Cycles after reset release before the boot pins are captured
	localparam logic [1:0] SNCR_BOOT_CAP_CYC = 2'h2;

	typedef enum {
		SNCR_PLL_IDLE,
		SNCR_PLL_SETTLE,
		SNCR_PLL_WAIT_LOCK
	} sncr_pll_state_t;
endpackage : sncr_pkg

// ==== verification/sncr_node_config_asserts.sv ====
`timescale 1ns/100ps
module sncr_node_config_asserts (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic cfg_wr, // Write
	input wire logic cfg_rd, // Read
	input wire logic [7:0] cfg_num, // Number
	input wire logic [31:0] cfg_wdata, // Data
	input wire logic [31:0] cfg_rdata, // Data
	input wire logic cfg_rack, // Ack
	input wire logic cfg_wack, // Ack
	input wire logic cfg_wdenied, // Denied
	input wire logic header_one_byte, // Mode
	input wire logic [15:0] node_id, // Id
	input wire logic [2:0] pll_out_div, // Field
	input wire logic [12:0] pll_fb_mul, // Field
	input wire logic [6:0] pll_in_div, // Field
	input wire logic pll_bypass, // Field
	input wire logic boot_from_jtag, // Field
	input wire logic pll_busy, // Busy
	input wire logic tile_reset, // Reset out
	input wire logic route_req, // Lookup
	input wire logic [15:0] route_dest, // Dest
	input wire logic route_valid, // Valid
	input wire logic route_local, // Local
	input wire logic in_debug_flag, // Debug
	input wire logic global_debug_line_n_out, // Drive
	input wire logic global_debug_line_n_oe, // Enable
	input wire logic debug_request // Request
);
	import sncr_pkg::*;
	logic [7:0] wnum_q;
	logic [31:0] wdat_q;
	logic lock_r;
	// Ack arrives one cycle after the write, so the captured write matches it
	wire acc = cfg_wack && !cfg_wdenied;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wnum_q <= 8'h00;
			wdat_q <= 32'h00000000;
		end else if (cfg_wr) begin
			wnum_q <= cfg_num;
			wdat_q <= cfg_wdata;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= 1'b0;
		end else if (acc && wnum_q == SNCR_REG_SW_CFG && wdat_q[31]) begin
			lock_r <= 1'b1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_write_ack: assert property (cfg_wr |=> cfg_wack)
		else $error("write not acknowledged");
	a_read_ack: assert property (cfg_rd && !cfg_wr |=> cfg_rack)
		else $error("read not acknowledged");
	a_node_hold: assert property (!cfg_wr |=> $stable(node_id))
		else $error("node id changed without write");
	a_lock_all: assert property (lock_r && cfg_wr |=> cfg_wdenied)
		else $error("write accepted while bank locked");
	a_ro_denied: assert property (cfg_wr && (cfg_num == SNCR_REG_DEV_ID ||
		cfg_num == SNCR_REG_SW_DESC) |=> cfg_wdenied)
		else $error("read-only write accepted");
	a_busy_refuse: assert property (cfg_wr && cfg_num == SNCR_REG_PLL &&
		pll_busy |=> cfg_wdenied)
		else $error("pll write accepted while busy");
	a_pll_fields: assert property (acc && wnum_q == SNCR_REG_PLL |->
		pll_bypass == wdat_q[29] && boot_from_jtag == wdat_q[28] &&
		pll_out_div == wdat_q[25:23] && pll_fb_mul == wdat_q[20:8] &&
		pll_in_div == wdat_q[6:0])
		else $error("pll fields differ from write");
	a_tile_reset: assert property (acc && wnum_q == SNCR_REG_PLL |->
		tile_reset == !wdat_q[31])
		else $error("tile reset wrong after pll write");
	a_relock_skip: assert property (acc && wnum_q == SNCR_REG_PLL &&
		wdat_q[30] |-> !pll_busy ##1 !tile_reset)
		else $error("relock wait not skipped");
	a_header_mode: assert property (acc && wnum_q == SNCR_REG_SW_CFG |->
		header_one_byte == wdat_q[0])
		else $error("header mode wrong");
	a_debug_drive: assert property (global_debug_line_n_oe |->
		!global_debug_line_n_out && in_debug_flag)
		else $error("debug line driven wrongly");
	a_route_local: assert property (route_req && !cfg_wr &&
		route_dest == node_id |=> route_valid && route_local)
		else $error("local route missed");
	c_pll_write: cover property (acc && wnum_q == SNCR_REG_PLL);
	c_route_local: cover property (route_valid && route_local);
	c_debug_req: cover property (debug_request);
endmodule : sncr_node_config_asserts
bind sncr_node_config sncr_node_config_asserts i_sncr_node_config_asserts (
	.clk_sys, .rst_n, .cfg_wr, .cfg_rd, .cfg_num, .cfg_wdata, .cfg_rdata,
	.cfg_rack, .cfg_wack, .cfg_wdenied, .header_one_byte, .node_id,
	.pll_out_div, .pll_fb_mul, .pll_in_div, .pll_bypass, .boot_from_jtag,
	.pll_busy, .tile_reset, .route_req, .route_dest, .route_valid,
	.route_local, .in_debug_flag, .global_debug_line_n_out,
	.global_debug_line_n_oe, .debug_request);

// ==== verification/tb_sncr_node_config.sv ====
`timescale 1ns/100ps
module tb_sncr_node_config;
	import sncr_pkg::*;
	logic clk_sys, rst_n, cfg_wr, cfg_rd, route_req, pll_locked;
	logic in_debug_flag, global_debug_line_n_in;
	logic [7:0] cfg_num, boot_control_pins;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [13:0] otp_user_code;
	logic [15:0] route_dest, node_id, sw_clk_div, ref_clk_div;
	logic cfg_rack, cfg_wack, cfg_wdenied, header_one_byte, pll_bypass;
	logic boot_from_jtag, pll_busy, tile_reset, route_valid, route_local;
	logic global_debug_line_n_out, global_debug_line_n_oe, debug_request;
	logic [2:0] pll_out_div;
	logic [12:0] pll_fb_mul;
	logic [6:0] pll_in_div;
	logic [3:0] route_dir;
	int fail_count, checks_done;
	sncr_node_config i_sncr_node_config (
		.clk_sys, .rst_n, .cfg_wr, .cfg_rd, .cfg_num, .cfg_wdata, .cfg_rdata,
		.cfg_rack, .cfg_wack, .cfg_wdenied, .boot_control_pins,
		.otp_user_code, .header_one_byte, .node_id, .pll_out_div,
		.pll_fb_mul, .pll_in_div, .pll_bypass, .boot_from_jtag, .pll_locked,
		.pll_busy, .tile_reset, .sw_clk_div, .ref_clk_div, .route_req,
		.route_dest, .route_valid, .route_local, .route_dir, .in_debug_flag,
		.global_debug_line_n_in, .global_debug_line_n_out,
		.global_debug_line_n_oe, .debug_request);
	task automatic end_of_test();
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] n, input logic [31:0] d,
		input logic den);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_num <= n;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		// Acks stand one cycle only, so look just after the edge raising them
		#1;
		chk({30'h0, cfg_wack, cfg_wdenied}, {30'h0, 1'b1, den});
	endtask : wr
	task automatic rd(input logic [7:0] n, input logic [31:0] exp);
		@(posedge clk_sys);
		cfg_rd <= 1'b1;
		cfg_num <= n;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		chk({31'h0, cfg_rack}, 32'h1);
		chk(cfg_rdata, exp);
	endtask : rd
	task automatic rt(input logic [15:0] dest, input logic [5:0] exp);
		@(posedge clk_sys);
		route_req <= 1'b1;
		route_dest <= dest;
		@(posedge clk_sys);
		route_req <= 1'b0;
		#1;
		chk({26'h0, route_valid, route_local, route_dir}, {26'h0, exp});
	endtask : rt
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Generous span: the whole sequence needs well under 1000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end
	initial begin
		{rst_n, cfg_wr, cfg_rd, route_req, in_debug_flag} = 5'h00;
		{pll_locked, global_debug_line_n_in} = 2'b11;
		{cfg_num, cfg_wdata, route_dest} = 56'h0;
		boot_control_pins = 8'hA5;
		otp_user_code = 14'h2AB5;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(SNCR_REG_DEV_ID, 32'h00A50000);
		rd(SNCR_REG_SW_DESC, 32'h00080202);
		rd(SNCR_REG_SW_CFG, 32'h0);
		rd(SNCR_REG_NODE_ID, 32'h0);
		rd(SNCR_REG_SW_CLK_DIV, 32'h0);
		rd(SNCR_REG_REF_CLK_DIV, 32'h3);
		rd(SNCR_REG_SCAN_ID, 32'h1);
		rd(SNCR_REG_USER_CODE, {otp_user_code, 18'h0});
		rd(SNCR_REG_DIR_LOW, 32'h0);
		rd(SNCR_REG_DIR_HIGH, 32'h0);
		rd(SNCR_REG_DBG_TILE0, 32'h0);
		wr(SNCR_REG_NODE_ID, 32'hFFFF1234, 1'b0);
		rd(SNCR_REG_NODE_ID, 32'h00001234);
		chk({16'h0, node_id}, 32'h1234);
		wr(SNCR_REG_SW_CLK_DIV, 32'hFFFFABCD, 1'b0);
		chk({16'h0, sw_clk_div}, 32'hABCD);
		wr(SNCR_REG_REF_CLK_DIV, 32'hFFFF5A5A, 1'b0);
		rd(SNCR_REG_REF_CLK_DIV, 32'h00005A5A);
		chk({16'h0, ref_clk_div}, 32'h5A5A);
		wr(SNCR_REG_DIR_LOW, 32'h76543210, 1'b0);
		wr(SNCR_REG_DIR_HIGH, 32'hFEDCBA98, 1'b0);
		rd(SNCR_REG_DIR_HIGH, 32'hFEDCBA98);
		wr(SNCR_REG_SW_CFG, 32'h7FFFFEFF, 1'b0);
		rd(SNCR_REG_SW_CFG, 32'h1);
		chk({31'h0, header_one_byte}, 32'h1);
		wr(SNCR_REG_DEV_ID, 32'hFFFFFFFF, 1'b1);
		rd(SNCR_REG_DEV_ID, 32'h00A50000);
		wr(8'h02, 32'hFFFFFFFF, 1'b1);
		rd(8'h02, 32'h0);
		for (int d = 0; d < 16; d++)
			rt(16'h1234 ^ (16'h1 << d), {2'b10, 4'(d)});
		rt(16'h1234, 6'h30);
		wr(SNCR_REG_DBG_TILE0, 32'hFFFFFFFF, 1'b0);
		rd(SNCR_REG_DBG_TILE0, 32'h3);
		in_debug_flag <= 1'b1;
		global_debug_line_n_in <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		chk({30'h0, global_debug_line_n_oe, debug_request}, 32'h3);
		wr(SNCR_REG_DBG_TILE0, 32'h0, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({30'h0, global_debug_line_n_oe, debug_request}, 32'h0);
		wr(SNCR_REG_PLL, 32'hFFFFFFFF, 1'b0);
		chk({30'h0, tile_reset, pll_busy}, 32'h0);
		chk({pll_bypass, boot_from_jtag, pll_out_div, pll_fb_mul, pll_in_div},
			32'h1FFFFFF);
		rd(SNCR_REG_PLL, SNCR_PLL_WMASK);
		wr(SNCR_REG_PLL, 32'h40801505, 1'b0);
		chk({30'h0, tile_reset, pll_busy}, 32'h2);
		@(posedge clk_sys);
		#1;
		chk({31'h0, tile_reset}, 32'h0);
		chk({pll_out_div, pll_fb_mul, pll_in_div}, 32'h100A85);
		pll_locked <= 1'b0;
		wr(SNCR_REG_PLL, 32'h0, 1'b0);
		chk({30'h0, tile_reset, pll_busy}, 32'h3);
		repeat (15) @(posedge clk_sys);
		wr(SNCR_REG_PLL, 32'h0, 1'b1);
		chk({30'h0, tile_reset, pll_busy}, 32'h3);
		pll_locked <= 1'b1;
		for (int i = 0; i < 20 && pll_busy !== 1'b0; i++)
			@(posedge clk_sys);
		#1;
		chk({30'h0, tile_reset, pll_busy}, 32'h0);
		wr(SNCR_REG_SW_CFG, 32'h00000100, 1'b0);
		wr(SNCR_REG_PLL, 32'h80000001, 1'b1);
		rd(SNCR_REG_PLL, 32'h0);
		wr(SNCR_REG_SW_CFG, 32'h80000101, 1'b0);
		wr(SNCR_REG_NODE_ID, 32'h0, 1'b1);
		rd(SNCR_REG_NODE_ID, 32'h00001234);
		wr(SNCR_REG_SW_CFG, 32'h0, 1'b1);
		rd(SNCR_REG_SW_CFG, 32'h80000101);
		end_of_test();
	end
endmodule : tb_sncr_node_config

// ==== verilog/sncr_node_config.sv ====
`timescale 1ns/100ps

// Overview of operation
// - Identification bits 23:16 show boot pins caught at power-on reset.
// - Identification bits 15:8 give switch revision, bits 7:0 switch version.
// - Description gives link count, switch and device processor counts.
// - Switch configuration bit 31 set blocks all writes to the bank.
// - Switch configuration bit 8 set blocks writes to PLL settings register.
// - Node identifier register holds writable 16-bit id, reset to zero.
// - A PLL settings write resets the tile unless suppressed.
// - PLL write with bit 31 set applies settings without chip reset.
// - PLL write with bit 30 set skips waiting for PLL relock.
// - PLL bit 29 bypasses the PLL for the core clock.
// - PLL bit 28 forces boot from the scan port.
// - Output divider in bits 25:23 holds ratio minus one.
// - Feedback multiplier in bits 20:8 holds ratio minus one.
// - Input divider in bits 6:0 holds ratio minus one.
// - Switch clock divider is a writable 16-bit field resetting to 0.
// - Reference clock divider is a writable 16-bit field resetting to 3.
// - User code register returns user code 31:18 and fixable id 17:0.
// - Route by highest mismatching id bit; low table covers bits 7..0.
// - High direction table covers mismatches in id bits 15..8.
// - Each table packs eight 4-bit directions, lowest dimension in bits 3:0.
// - Debug config bit 0 lets in-debug flag drive the global debug line.
// - Debug config bit 1 lets the global debug line request processor debug.
module sncr_node_config #(
	parameter logic [7:0] SW_REVISION = 8'h00,   // Arbitrary value
	parameter logic [7:0] SW_VERSION = 8'h00,    // Arbitrary value
	parameter logic [7:0] NUM_SERIAL_LINKS = 8'h08,
	parameter logic [7:0] NUM_SW_PROCS = 8'h02,
	parameter logic [7:0] NUM_DEV_PROCS = 8'h02,
	parameter logic [31:0] SCAN_DEVICE_ID = 32'h00000001, // Arbitrary value
	parameter logic [17:0] METAL_ID = 18'h00000,  // Arbitrary value
	parameter logic [31:0] PLL_RESET = sncr_pkg::SNCR_PLL_RST
) (
	input wire logic clk_sys,                   // Switch clock
	input wire logic rst_n,                     // Power-on reset
	input wire logic cfg_wr,                    // Configuration write
	input wire logic cfg_rd,                    // Configuration read
	input wire logic [7:0] cfg_num,             // Register number
	input wire logic [31:0] cfg_wdata,          // Write data
	output logic [31:0] cfg_rdata,              // Read data
	output logic cfg_rack,                      // Read data valid
	output logic cfg_wack,                      // Write completed
	output logic cfg_wdenied,                   // Write had no effect
	input wire logic [7:0] boot_control_pins,   // Boot strap pins
	input wire logic [13:0] otp_user_code,      // Programmed user code
	output logic header_one_byte,               // One-byte headers
	output logic [15:0] node_id,                // Node identifier
	output logic [2:0] pll_out_div,             // Output divider minus one
	output logic [12:0] pll_fb_mul,             // Multiplier minus one
	output logic [6:0] pll_in_div,              // Input divider minus one
	output logic pll_bypass,                    // Core clock bypasses PLL
	output logic boot_from_jtag,                // Forced scan port boot
	input wire logic pll_locked,                // PLL lock indication
	output logic pll_busy,                      // Waiting for relock
	output logic tile_reset,                    // Tile reset request
	output logic [15:0] sw_clk_div,             // Switch clock divider
	output logic [15:0] ref_clk_div,            // Reference clock divider
	input wire logic route_req,                 // Route lookup request
	input wire logic [15:0] route_dest,         // Destination node id
	output logic route_valid,                   // Lookup result valid
	output logic route_local,                   // Destination is this node
	output logic [3:0] route_dir,               // Chosen direction
	input wire logic in_debug_flag,             // Tile is in debug
	input wire logic global_debug_line_n_in,    // Debug line level
	output logic global_debug_line_n_out,       // Debug line drive value
	output logic global_debug_line_n_oe,        // Debug line drive enable
	output logic debug_request                  // Debug request to core
);
	import sncr_pkg::*;

	// Index of the highest set bit; only meaningful for a nonzero word
	function automatic logic [3:0] msb_index(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : msb_index

	// Selects the 4-bit direction field for one dimension of a table
	function automatic logic [3:0] dir_field(input logic [31:0] tbl,
			input logic [2:0] dim);
		return tbl[{dim, 2'h0} +: 4];
	endfunction : dir_field

	logic [31:0] sw_cfg_r;
	logic [15:0] node_id_r;
	logic [31:0] pll_r;
	logic [15:0] sw_clk_div_r;
	logic [15:0] ref_clk_div_r;
	logic [31:0] dir_low_r;
	logic [31:0] dir_high_r;
	logic [1:0] dbg_cfg_r;
	logic [7:0] boot_meta_r;
	logic [7:0] boot_sync_r;
	logic [7:0] boot_cap_r;
	logic [1:0] boot_cnt_r;
	logic boot_done_r;
	logic [13:0] otp_meta_r;
	logic [13:0] otp_sync_r;
	logic lock_meta_r;
	logic lock_sync_r;
	logic dbg_meta_r;
	logic dbg_sync_r;
	sncr_pll_state_t pll_state_r;
	sncr_pll_state_t pll_state_nxt;
	logic [7:0] settle_cnt_r;
	logic no_reset_r;
	logic tile_reset_r;
	logic tile_reset_nxt;
	logic [31:0] cfg_rdata_r;
	logic cfg_rack_r;
	logic cfg_wack_r;
	logic cfg_wdenied_r;
	logic route_valid_r;
	logic route_local_r;
	logic [3:0] route_dir_r;
	logic debug_request_r;

	// Write qualification
	wire bank_locked = sw_cfg_r[SNCR_CFG_LOCK_ALL_BIT];
	wire pll_locked_out = sw_cfg_r[SNCR_CFG_LOCK_PLL_BIT];
	wire wr_ok = cfg_wr && !bank_locked;
	wire wr_cfg = wr_ok && (cfg_num == SNCR_REG_SW_CFG);
	wire wr_node = wr_ok && (cfg_num == SNCR_REG_NODE_ID);
	// A PLL write while a relock is pending is dropped, so a half-applied
	// sequence can never stack a second tile reset on the first
	wire wr_pll = wr_ok && (cfg_num == SNCR_REG_PLL) && !pll_locked_out &&
		(pll_state_r == SNCR_PLL_IDLE);
	wire wr_swdiv = wr_ok && (cfg_num == SNCR_REG_SW_CLK_DIV);
	wire wr_refdiv = wr_ok && (cfg_num == SNCR_REG_REF_CLK_DIV);
	wire wr_dlow = wr_ok && (cfg_num == SNCR_REG_DIR_LOW);
	wire wr_dhigh = wr_ok && (cfg_num == SNCR_REG_DIR_HIGH);
	wire wr_dbg = wr_ok && (cfg_num == SNCR_REG_DBG_TILE0);
	wire wr_hit = wr_cfg || wr_node || wr_pll || wr_swdiv || wr_refdiv ||
		wr_dlow || wr_dhigh || wr_dbg;

	// Only the defined fields of the switch configuration are kept
	wire [31:0] sw_cfg_wval = {cfg_wdata[SNCR_CFG_LOCK_ALL_BIT], 22'h000000,
		cfg_wdata[SNCR_CFG_LOCK_PLL_BIT], 7'h00,
		cfg_wdata[SNCR_CFG_HDR_BIT]};
	wire [31:0] pll_wval = cfg_wdata & SNCR_PLL_WMASK;

	// Read selection
	wire [31:0] rd_dev_id = {8'h00, boot_cap_r, SW_REVISION,
		SW_VERSION};
	wire [31:0] rd_desc = {8'h00, NUM_SERIAL_LINKS, NUM_SW_PROCS,
		NUM_DEV_PROCS};
	wire [31:0] rd_user = {otp_sync_r, METAL_ID};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (cfg_num)
			SNCR_REG_DEV_ID: rd_mux = rd_dev_id;
			SNCR_REG_SW_DESC: rd_mux = rd_desc;
			SNCR_REG_SW_CFG: rd_mux = sw_cfg_r;
			SNCR_REG_NODE_ID: rd_mux = {16'h0000, node_id_r};
			SNCR_REG_PLL: rd_mux = pll_r;
			SNCR_REG_SW_CLK_DIV: rd_mux = {16'h0000, sw_clk_div_r};
			SNCR_REG_REF_CLK_DIV: rd_mux = {16'h0000, ref_clk_div_r};
			SNCR_REG_SCAN_ID: rd_mux = SCAN_DEVICE_ID;
			SNCR_REG_USER_CODE: rd_mux = rd_user;
			SNCR_REG_DIR_LOW: rd_mux = dir_low_r;
			SNCR_REG_DIR_HIGH: rd_mux = dir_high_r;
			SNCR_REG_DBG_TILE0: rd_mux = {30'h00000000, dbg_cfg_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Configuration port: one access per cycle, answered a cycle later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata_r <= 32'h00000000;
			cfg_rack_r <= 1'b0;
			cfg_wack_r <= 1'b0;
			cfg_wdenied_r <= 1'b0;
		end else begin
			cfg_rack_r <= cfg_rd && !cfg_wr;
			cfg_wack_r <= cfg_wr;
			cfg_wdenied_r <= cfg_wr && !wr_hit;
			if (cfg_rd && !cfg_wr) begin
				cfg_rdata_r <= rd_mux;
			end
		end
	end

	// Writable registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sw_cfg_r <= 32'h00000000;
			node_id_r <= SNCR_NODE_ID_RST;
			sw_clk_div_r <= SNCR_SW_CLK_DIV_RST;
			ref_clk_div_r <= SNCR_REF_CLK_DIV_RST;
			dir_low_r <= SNCR_DIR_RST;
			dir_high_r <= SNCR_DIR_RST;
			dbg_cfg_r <= 2'h0;
		end else begin
			if (wr_cfg) begin
				sw_cfg_r <= sw_cfg_wval;
			end
			if (wr_node) begin
				node_id_r <= cfg_wdata[15:0];
			end
			if (wr_swdiv) begin
				sw_clk_div_r <= cfg_wdata[15:0];
			end
			if (wr_refdiv) begin
				ref_clk_div_r <= cfg_wdata[15:0];
			end
			if (wr_dlow) begin
				dir_low_r <= cfg_wdata;
			end
			if (wr_dhigh) begin
				dir_high_r <= cfg_wdata;
			end
			if (wr_dbg) begin
				dbg_cfg_r <= {cfg_wdata[SNCR_DBG_REQ_BIT],
					cfg_wdata[SNCR_DBG_DRIVE_BIT]};
			end
		end
	end

	// PLL settings register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_r <= PLL_RESET;
		end else if (wr_pll) begin
			pll_r <= pll_wval;
		end
	end

	// Relock sequence. The lock flag may still read high from the old
	// setting, so a settle delay passes before it is believed again.
	always_comb begin
		pll_state_nxt = pll_state_r;
		unique case (pll_state_r)
			SNCR_PLL_IDLE: begin
				if (wr_pll && !cfg_wdata[SNCR_PLL_NO_RELOCK_BIT]) begin
					pll_state_nxt = SNCR_PLL_SETTLE;
				end
			end
			SNCR_PLL_SETTLE: begin
				if (settle_cnt_r == SNCR_SETTLE_LAST) begin
					pll_state_nxt = SNCR_PLL_WAIT_LOCK;
				end
			end
			SNCR_PLL_WAIT_LOCK: begin
				if (lock_sync_r) begin
					pll_state_nxt = SNCR_PLL_IDLE;
				end
			end
		endcase
	end

	// Tile reset is held for the whole relock, or one cycle if relock is
	// skipped
	always_comb begin
		tile_reset_nxt = 1'b0;
		if (wr_pll) begin
			tile_reset_nxt = !cfg_wdata[SNCR_PLL_NO_RESET_BIT];
		end else if (pll_state_nxt != SNCR_PLL_IDLE) begin
			tile_reset_nxt = !no_reset_r;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pll_state_r <= SNCR_PLL_IDLE;
			settle_cnt_r <= 8'h00;
			no_reset_r <= 1'b0;
			tile_reset_r <= 1'b0;
		end else begin
			pll_state_r <= pll_state_nxt;
			tile_reset_r <= tile_reset_nxt;
			if (wr_pll) begin
				no_reset_r <= cfg_wdata[SNCR_PLL_NO_RESET_BIT];
			end
			if (pll_state_r == SNCR_PLL_SETTLE) begin
				settle_cnt_r <= settle_cnt_r + 8'h01;
			end else begin
				settle_cnt_r <= 8'h00;
			end
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_meta_r <= 8'h00;
			boot_sync_r <= 8'h00;
			otp_meta_r <= 14'h0000;
			otp_sync_r <= 14'h0000;
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
			dbg_meta_r <= 1'b1;
			dbg_sync_r <= 1'b1;
		end else begin
			boot_meta_r <= boot_control_pins;
			boot_sync_r <= boot_meta_r;
			otp_meta_r <= otp_user_code;
			otp_sync_r <= otp_meta_r;
			lock_meta_r <= pll_locked;
			lock_sync_r <= lock_meta_r;
			dbg_meta_r <= global_debug_line_n_in;
			dbg_sync_r <= dbg_meta_r;
		end
	end

	// Boot pins are caught once, after the synchroniser has filled, and
	// then frozen until the next power-on reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_cap_r <= 8'h00;
			boot_cnt_r <= 2'h0;
			boot_done_r <= 1'b0;
		end else if (!boot_done_r) begin
			if (boot_cnt_r == SNCR_BOOT_CAP_CYC) begin
				boot_cap_r <= boot_sync_r;
				boot_done_r <= 1'b1;
			end else begin
				boot_cnt_r <= boot_cnt_r + 2'h1;
			end
		end
	end

	// Route lookup
	wire [15:0] mismatch = route_dest ^ node_id_r;
	wire [3:0] dim = msb_index(mismatch);
	wire [3:0] dir_sel = dim[3] ? dir_field(dir_high_r, dim[2:0]) :
		dir_field(dir_low_r, dim[2:0]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			route_valid_r <= 1'b0;
			route_local_r <= 1'b0;
			route_dir_r <= 4'h0;
		end else begin
			route_valid_r <= route_req;
			if (route_req) begin
				route_local_r <= (mismatch == 16'h0000);
				route_dir_r <= dir_sel;
			end
		end
	end

	// Debug line is open drain and active low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			debug_request_r <= 1'b0;
		end else begin
			debug_request_r <= dbg_cfg_r[SNCR_DBG_REQ_BIT] &&
				!dbg_sync_r;
		end
	end

	assign global_debug_line_n_out = 1'b0;
	assign global_debug_line_n_oe = dbg_cfg_r[SNCR_DBG_DRIVE_BIT] &&
		in_debug_flag;

	assign cfg_rdata = cfg_rdata_r;
	assign cfg_rack = cfg_rack_r;
	assign cfg_wack = cfg_wack_r;
	assign cfg_wdenied = cfg_wdenied_r;
	assign header_one_byte = sw_cfg_r[SNCR_CFG_HDR_BIT];
	assign node_id = node_id_r;
	assign pll_out_div = pll_r[SNCR_PLL_OUT_DIV_HI:SNCR_PLL_OUT_DIV_LO];
	assign pll_fb_mul = pll_r[SNCR_PLL_FB_MUL_HI:SNCR_PLL_FB_MUL_LO];
	assign pll_in_div = pll_r[SNCR_PLL_IN_DIV_HI:SNCR_PLL_IN_DIV_LO];
	assign pll_bypass = pll_r[SNCR_PLL_BYPASS_BIT];
	assign boot_from_jtag = pll_r[SNCR_PLL_JTAG_BOOT_BIT];
	assign pll_busy = (pll_state_r != SNCR_PLL_IDLE);
	assign tile_reset = tile_reset_r;
	assign sw_clk_div = sw_clk_div_r;
	assign ref_clk_div = ref_clk_div_r;
	assign route_valid = route_valid_r;
	assign route_local = route_local_r;
	assign route_dir = route_dir_r;
	assign debug_request = debug_request_r;
endmodule : sncr_node_config
